// File: src/sidfm_regs.v
`include "sidfm_map.vh"

// Notes on behaviour
// - status bit 17 high during conversion
// - status bits 16:12 hold channel index
// - status bits 11:0 hold that channel's result
// - bit 21 mirrors alarm pin level in all words but the variant word
// - identity bits 7:0 give die revision
// - master clock divided by ten thousand
// - each tick advances wrapping 16-bit counter
// - tick counter readable in bits 15:0
// - monitor enabled after reset, bit controllable
// - variant word bit 21 is inverted alarm
// - status address 0x16, reset image 0x160000
module sidfm_regs #(
    parameter TICK_DIV = `SIDFM_TICK_DIV,
    parameter [7:0] DIE_REVISION = 8'h5a, // arbitrary value
    parameter [2:0] VARIANT_CODE = 3'h5 // arbitrary value
) (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire [4:0] rd_addr_i,
    input wire alarm_pin_i,
    input wire conv_busy_i,
    input wire result_valid_i,
    input wire [4:0] converted_channel_index_i,
    input wire [11:0] conv_result_i,
    input wire oscillator_check_enable_i,
    output reg [21:0] rd_data_o,
    output reg [15:0] oscillator_tick_count_o
);
    reg [4:0] converted_channel_index;
    reg [11:0] conv_result;
    reg conv_busy;
    wire tick;
    wire [15:0] tick_count;
    reg [21:0] next_rd_data;

    // ----------------------------------------
    // Header of every readback word
    // ----------------------------------------
    function [21:0] sidfm_head;
        input [4:0] addr;
        input alarm;
        begin
            sidfm_head = 22'h000000;
            sidfm_head[`SIDFM_ALARM_BIT] = alarm;
            sidfm_head[`SIDFM_ADDR_HI:`SIDFM_ADDR_LO] = addr;
        end
    endfunction

    // ----------------------------------------
    // Conversion capture
    // ----------------------------------------
    // Channel and result load together so they never disagree
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            converted_channel_index <= 5'h00;
            conv_result <= 12'h000;
            conv_busy <= 1'b0;
        end else begin
            conv_busy <= conv_busy_i;
            if (result_valid_i) begin
                converted_channel_index <= converted_channel_index_i;
                conv_result <= conv_result_i;
            end
        end
    end

    // ----------------------------------------
    // Frequency monitor
    // ----------------------------------------
    // Enable comes from setup register, resetting high outside this block
    sidfm_tick_div #(
        .DIV(TICK_DIV)
    ) u_div (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .enable_i(oscillator_check_enable_i),
        .tick_o(tick)
    );

    sidfm_tick_cnt #(
        .WIDTH(16)
    ) u_cnt (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .tick_i(tick),
        .count_o(tick_count)
    );

    // ----------------------------------------
    // Readback multiplexer
    // ----------------------------------------
    // Unmapped addresses return the header only; reserved bits are zero
    always @* begin
        next_rd_data = sidfm_head(rd_addr_i, alarm_pin_i);
        case (rd_addr_i)
            `SIDFM_ADDR_STATUS: begin
                next_rd_data[`SIDFM_BUSY_BIT] = conv_busy;
                next_rd_data[`SIDFM_CH_HI:`SIDFM_CH_LO] = converted_channel_index;
                next_rd_data[`SIDFM_DATA_HI:`SIDFM_DATA_LO] = conv_result;
            end
            `SIDFM_ADDR_DIE_ID: begin
                next_rd_data[7:0] = DIE_REVISION;
            end
            `SIDFM_ADDR_TICK: begin
                next_rd_data[15:0] = tick_count;
            end
            `SIDFM_ADDR_VARIANT: begin
                next_rd_data[`SIDFM_ALARM_BIT] = ~alarm_pin_i;
                next_rd_data[2:0] = VARIANT_CODE;
            end
            default: begin
                next_rd_data = sidfm_head(rd_addr_i, alarm_pin_i);
            end
        endcase
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    // Reset image is the header alone for the status address, so bit 17 (busy) reads high
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_o <= `SIDFM_STATUS_RESET;
            oscillator_tick_count_o <= 16'h0000;
        end else begin
            rd_data_o <= next_rd_data;
            oscillator_tick_count_o <= tick_count;
        end
    end
endmodule

// File: src/sidfm_map.vh
`ifndef SIDFM_MAP_VH
`define SIDFM_MAP_VH

// ----------------------------------------
// Register addresses (5-bit)
// ----------------------------------------
`define SIDFM_ADDR_STATUS 5'h16
`define SIDFM_ADDR_DIE_ID 5'h17
`define SIDFM_ADDR_TICK 5'h18
`define SIDFM_ADDR_VARIANT 5'h1c

// ----------------------------------------
// Field positions of the 22-bit readback word
// ----------------------------------------
`define SIDFM_ALARM_BIT 21
`define SIDFM_ADDR_HI 20
`define SIDFM_ADDR_LO 16
`define SIDFM_BUSY_BIT 17
`define SIDFM_CH_HI 16
`define SIDFM_CH_LO 12
`define SIDFM_DATA_HI 11
`define SIDFM_DATA_LO 0

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define SIDFM_STATUS_RESET 22'h160000
`define SIDFM_TICK_RESET 22'h180000
`define SIDFM_CHECK_EN_RESET 1'b1
`define SIDFM_MCLK_HZ 100000000
`define SIDFM_TICK_HZ 1000
`define SIDFM_TICK_DIV 10000

`endif

// File: src/sidfm_tick_div.v
`include "sidfm_map.vh"

// Divider that makes one single-cycle tick every DIV clocks
module sidfm_tick_div #(
    parameter DIV = `SIDFM_TICK_DIV
) (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire enable_i,
    output reg tick_o
);
    reg [15:0] count;

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    // Count held at zero while disabled so a restart gives a full period
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count <= 16'h0000;
            tick_o <= 1'b0;
        end else if (!enable_i) begin
            count <= 16'h0000;
            tick_o <= 1'b0;
        end else if (count == DIV[15:0] - 16'h0001) begin
            count <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            count <= count + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule

// File: src/sidfm_tick_cnt.v
// Sixteen-bit wrapping counter advanced by each tick
module sidfm_tick_cnt #(
    parameter WIDTH = 16
) (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire tick_i,
    output reg [WIDTH-1:0] count_o
);
    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // Natural wrap; host works out rate from differences
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_o <= {WIDTH{1'b0}};
        end else if (tick_i) begin
            count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule

// File: tb/sidfm_regs_properties.sv
// ----------------------------------------
// Readback word and tick counter checks
// ----------------------------------------
module sidfm_regs_properties (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire [4:0] rd_addr_i,
    input wire alarm_pin_i,
    input wire conv_busy_i,
    input wire result_valid_i,
    input wire [4:0] converted_channel_index_i,
    input wire [11:0] conv_result_i,
    input wire oscillator_check_enable_i,
    input wire [21:0] rd_data_o,
    input wire [15:0] oscillator_tick_count_o
);
    wire [4:0] a = rd_addr_i;
    wire [21:0] d = rd_data_o;
    wire [15:0] cnt = oscillator_tick_count_o;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // Three idle cycles so that no tick is still on its way
    sequence s_mon_off;
        !oscillator_check_enable_i [*3];
    endsequence
    sequence s_step;
        $changed(cnt) && oscillator_check_enable_i;
    endsequence
    a_alarm_mirror: assert property (a != 5'h1c |=> d[21] == $past(alarm_pin_i))
        else $error("alarm bit wrong");
    a_alarm_invert: assert property (a == 5'h1c |=> d[21] == !$past(alarm_pin_i))
        else $error("inverted alarm bit wrong");
    a_addr_echo: assert property (a != 5'h16 |=> d[20:16] == $past(a))
        else $error("address field wrong");
    a_die_revision: assert property (a == 5'h17 |=> d[15:0] == 16'h005a)
        else $error("revision word wrong");
    a_variant_code: assert property (a == 5'h1c |=> d[15:0] == 16'h0005)
        else $error("variant word wrong");
    a_tick_field: assert property (a == 5'h18 |=> d[15:0] == cnt)
        else $error("tick field wrong");
    a_count_step: assert property (s_step |-> cnt == $past(cnt) + 16'h1)
        else $error("counter step wrong");
    a_tick_spacing: assert property (s_step |=> $stable(cnt) [*8])
        else $error("tick spacing wrong");
    a_hold_off: assert property (s_mon_off |=> $stable(cnt))
        else $error("counter moved while off");
endmodule

bind sidfm_regs sidfm_regs_properties chk_u (.*);

// File: tb/sidfm_host.sv
// Host side: sets an address, picks up the answer a cycle later
module sidfm_host (
    input wire sys_clk_i,
    input wire [21:0] rd_data_i,
    output logic [4:0] rd_addr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rd_addr_o = 5'h00;
    task automatic poll(input logic [4:0] addr, output logic [21:0] word);
        @(negedge sys_clk_i) rd_addr_o = addr;
        @(negedge sys_clk_i) word = rd_data_i;
    endtask
endmodule

// File: tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, alarm = 1'b0, busy = 1'b0, valid = 1'b0, en = 1'b1;
    logic [4:0] addr, ch = 5'h00;
    logic [11:0] res = 12'h000;
    logic [21:0] word, got, exp_w;
    logic [15:0] cnt;
    logic [4:0] regs[$] = '{5'h17, 5'h18, 5'h1c, 5'h03};
    integer bad_count = 0, check_count = 0, cycles = 0, seed = 32'h31fbe0f9, base = 0, held = 0;
    sidfm_regs #(.TICK_DIV(10)) dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .rd_addr_i(addr),
        .alarm_pin_i(alarm), .conv_busy_i(busy), .result_valid_i(valid),
        .converted_channel_index_i(ch), .conv_result_i(res), .oscillator_check_enable_i(en),
        .rd_data_o(word), .oscillator_tick_count_o(cnt));
    sidfm_host host_u (.sys_clk_i(sys_clk_i), .rd_data_i(word), .rd_addr_o(addr));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    // Hang guard, also the time base of the tick model
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count = bad_count + 1;
            print_verdict();
        end
    end
    // ----------------------------------------
    // Model and helpers
    // ----------------------------------------
    function automatic logic [21:0] model(input logic [4:0] a);
        model = {(a == 5'h1c) ^ alarm, a, 16'h0000};
        case (a)
            5'h17: model[7:0] = 8'h5a;
            5'h18: model[15:0] = 16'(held + (en ? (cycles - base - 2) / 10 : 0));
            5'h1c: model[2:0] = 3'h5;
            default: ;
        endcase
    endfunction
    task automatic check(input logic [21:0] seen, input logic [21:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic do_reset();
        nrst_i = 1'b0;
        repeat (12) @(negedge sys_clk_i);
        check(word, 22'h160000);
        check(22'(cnt), 22'h0);
        nrst_i = 1'b1;
        base = cycles;
        held = 0;
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Reads of every word, then monitor off and on, then a second reset
    initial begin
        do_reset();
        repeat (3) begin
            foreach (regs[k]) begin
                @(negedge sys_clk_i) alarm = $random(seed);
                host_u.poll(regs[k], got);
                check(got, model(regs[k]));
            end
            @(negedge sys_clk_i) {ch, res} = $random(seed);
            valid = 1'b1;
            busy = $random(seed);
            @(negedge sys_clk_i) valid = 1'b0;
            host_u.poll(5'h16, got);
            // Bits 20:18 keep the address image; busy, channel and result overlay the rest
            check(got, {alarm, 3'b101, busy, ch, res});
        end
        while ((cycles - base) % 10 != 5) @(negedge sys_clk_i);
        held = model(5'h18);
        en = 1'b0;
        repeat (40) @(negedge sys_clk_i);
        host_u.poll(5'h18, got);
        check(got, model(5'h18));
        en = 1'b1;
        base = cycles;
        repeat (35) @(negedge sys_clk_i);
        host_u.poll(5'h18, got);
        check(got, model(5'h18));
        do_reset();
        repeat (25) @(negedge sys_clk_i);
        host_u.poll(5'h18, got);
        exp_w = model(5'h18);
        check(got, exp_w);
        check(22'(cnt), 22'(exp_w[15:0]));
        print_verdict();
    end
endmodule
